// ---- aoic_pkg.sv ----
// package: constants, types and helpers of the analog output image conditioner
package aoic_pkg;

  // clock and strobe timing
  localparam int CLK_MHZ = 50;
  localparam int STB_NS  = 40;
  localparam int STB_CYC = (STB_NS * CLK_MHZ + 999) / 1000;

  // channel geometry
  localparam int NCH     = 8;
  localparam int IMG_W   = 12;
  localparam int MSG_W   = 128;

  // wishbone byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [1:0] A_PAR  = 2'h1;

  // control and status fields
  localparam int CTRL_SCAN = 0;
  localparam int CTRL_LOST = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int ST_READY = 0;
  localparam int ST_BUSY  = 1;
  localparam int ST_STRAP = 2;
  localparam int ST_MODE  = 5;

  // table memory layout
  localparam logic [4:0] M_OFS  = 5'h00;
  localparam logic [4:0] M_GAIN = 5'h08;
  localparam logic [4:0] M_ZT   = 5'h10;
  localparam logic [4:0] M_GT   = 5'h18;

  // strap bit positions, a low pin means the jumper is installed
  localparam int JB_A = 0;
  localparam int JB_B = 1;
  localparam int JB_J = 2;

  // codes
  localparam logic [11:0] CODE_MAX     = 12'hfff;
  localparam logic [11:0] CODE_MIN     = 12'h000;
  localparam logic [15:0] STD_ZERO_DEF = 16'h0333;
  localparam logic [15:0] STD_GAIN_DEF = 16'h0fff;

  typedef enum logic [2:0] {
    FS_HIGH = 3'b001,
    FS_LOW  = 3'b010,
    FS_HOLD = 3'b100
  } aoic_fs_t;

  typedef struct packed {
    logic [7:0] data;
    logic       hstb_n;
    logic [7:0] sel_n;
  } aoic_dac_t;

  typedef struct packed {
    logic [7:0] data;
    logic       oe_n;
  } aoic_jmp_t;

  localparam aoic_dac_t DAC_RST = '{data: 8'h00, hstb_n: 1'b1, sel_n: 8'hff};
  localparam aoic_jmp_t JMP_RST = '{data: 8'h00, oe_n: 1'b1};

  // straps a and b pick the mode; none or both installed means hold
  function automatic aoic_fs_t fs_decode(input logic a_n, input logic b_n);
    if (!a_n && b_n) begin
      return FS_HIGH;
    end else if (a_n && !b_n) begin
      return FS_LOW;
    end
    return FS_HOLD;
  endfunction

  function automatic logic [11:0] clamp12(input logic signed [19:0] v);
    if (v < 0) begin
      return CODE_MIN;
    end else if (v > 20'sh00fff) begin
      return CODE_MAX;
    end
    return v[11:0];
  endfunction

  function automatic logic [15:0] justify(input logic left, input logic [11:0] c);
    return left ? {c, 4'h0} : {4'h0, c};
  endfunction

endpackage

// ---- aoic_mem.sv ----
// single port table memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module aoic_mem #(
  parameter int W  = 16,
  parameter int D  = 32,
  parameter int AW = 5
) (
  // clock
  input  wire logic          clk_i,
  // port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [W-1:0]  wdata_i,
  output logic      [W-1:0]  rdata_o
);
  logic [W-1:0] mem_q [D];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem_q[addr_i];
  end
endmodule
`default_nettype wire

// ---- aoic_top.sv ----
// analog output image conditioner: calibration, clamp, justify, converter loading, straps
// How it works
// - each of three straps reaches its own bit of the 8-bit jumper buffer
// - jumper buffer drives the data bus only while port select and read are low
// - straps choose one failsafe behaviour: drive high, drive low or hold
// - justify strap installed: 12-bit code moves up four bits
// - justify strap absent: code goes out unshifted, right justified
// - 16-bit converter word: code high with low nibble spare, or low
// - negative results become zero, results above 0fff become 0fff, no flag
// - zero table entry is the standard zero code plus channel offset
// - gain table entry is the standard gain code plus channel gain
// - tables are built from stored parameters on first scan entry, before output
// - images are calibrated before strobing, except with link lost in drive high or low mode, when fff or 000 is strobed
// - eight identical channels, each with its own 12-bit converter
// - an update carries eight images in sixteen bytes, all read each time
// - a normal update moves all eight images into the scan work buffer
// - high byte goes first with a common strobe, then the low byte
// - low byte write selects one converter from a three-bit channel code
// - conversion starts when the channel select returns high
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module aoic_top
  import aoic_pkg::*;
#(
  parameter logic [15:0] STD_ZERO = STD_ZERO_DEF,
  parameter logic [15:0] STD_GAIN = STD_GAIN_DEF
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // update message from the controller link
  input  wire logic              msg_valid_i,
  input  wire logic [MSG_W-1:0]  msg_data_i,
  // straps and local processor read port
  input  wire logic [2:0]        strap_n_i,
  input  wire logic              port_select_low_line_i,
  input  wire logic              proc_rd_n_i,
  output aoic_jmp_t              jmp_o,
  // converter bus and failsafe controls
  output aoic_dac_t              dac_o,
  output logic                   failsafe_level_ctl_o,
  output logic                   failsafe_hold_ctl_o
);

  typedef enum logic [11:0] {
    S_IDLE = 12'h001, S_BOFS = 12'h002, S_BGN = 12'h004, S_BWZ = 12'h008,
    S_BWG  = 12'h010, S_RZ   = 12'h020, S_RG  = 12'h040, S_CALC = 12'h080,
    S_HI   = 12'h100, S_HSTB = 12'h200, S_LO  = 12'h400, S_SEL  = 12'h800
  } aoic_st_t;

  aoic_st_t          st_q;
  logic [2:0]        ch_q;
  logic [1:0]        cnt_q;
  logic [4:0]        sync1_q;
  logic [4:0]        sync2_q;
  logic [1:0]        ctrl_q;
  logic              lost_d_q;
  logic              pend_q;
  logic              tready_q;
  logic              wb_stage_q;
  logic [11:0]       img_q [NCH];
  logic [15:0]       a_q;
  logic [15:0]       b_q;
  logic signed [19:0] raw_q;
  logic [11:0]       code_q;
  logic [15:0]       word_q;
  logic              forced_q;
  aoic_fs_t          mode;
  logic              lost;
  logic              wb_req;
  logic              is_par;
  logic              wb_hold;
  logic              wb_mem;
  logic              mem_we;
  logic [4:0]        mem_addr;
  logic [15:0]       mem_wdata;
  logic [15:0]       mem_rdata;
  logic [4:0]        fsm_addr;
  logic signed [16:0] z_s;
  logic signed [17:0] span;
  logic signed [30:0] prod;
  logic signed [19:0] raw_d;
  logic              step_done;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: {rd_n, port select, straps}

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 5'h1f;
      sync2_q <= 5'h1f;
    end else begin
      sync1_q <= {proc_rd_n_i, port_select_low_line_i, strap_n_i};
      sync2_q <= sync1_q;
    end
  end

  assign mode = fs_decode(sync2_q[JB_A], sync2_q[JB_B]);
  assign lost = ctrl_q[CTRL_LOST];

  // jumper buffer, only driven during a local read with port select low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      jmp_o <= JMP_RST;
    end else begin
      jmp_o.oe_n <= sync2_q[3] | sync2_q[4];
      jmp_o.data <= (sync2_q[3] | sync2_q[4]) ? 8'h00 : {5'h00, sync2_q[2:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      failsafe_level_ctl_o <= 1'b0;
      failsafe_hold_ctl_o  <= 1'b0;
    end else begin
      failsafe_level_ctl_o <= (mode == FS_HIGH);
      failsafe_hold_ctl_o  <= lost && (mode == FS_HOLD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: an access answers on the second edge after stb; parameter accesses wait until the sequencer is idle

  assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign is_par  = (wb_adr_i[7:6] == A_PAR);
  assign wb_hold = wb_stage_q | (wb_req & is_par);
  assign wb_mem  = (st_q == S_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_stage_q <= 1'b0;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
    end else begin
      wb_ack_o <= 1'b0;
      if (wb_stage_q) begin
        wb_stage_q <= 1'b0;
        wb_ack_o   <= 1'b1;
        if (is_par) begin
          wb_dat_o <= {16'h0000, mem_rdata};
        end else if (wb_adr_i == A_CTRL) begin
          wb_dat_o <= {30'h0, ctrl_q};
        end else if (wb_adr_i == A_STAT) begin
          wb_dat_o <= {24'h0, mode, sync2_q[2:0], ~wb_mem, tready_q};
        end else begin
          wb_dat_o <= 32'h0000_0000;
        end
      end else if (wb_req && (!is_par || wb_mem)) begin
        wb_stage_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (wb_req && !wb_stage_q && wb_we_i && wb_sel_i[0] && wb_adr_i == A_CTRL) begin
      ctrl_q <= wb_dat_i[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // message intake and scan request

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NCH; i++) begin
        img_q[i] <= 12'h000;
      end
    end else if (msg_valid_i) begin
      for (int i = 0; i < NCH; i++) begin
        img_q[i] <= {msg_data_i[16*i +: 4], msg_data_i[16*i+8 +: 8]};
      end
    end
  end

  // a new message or a fresh loss of link asks for a scan; set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q   <= 1'b0;
      lost_d_q <= 1'b0;
    end else begin
      lost_d_q <= lost;
      if (msg_valid_i || (lost && !lost_d_q)) begin
        pend_q <= 1'b1;
      end else if (st_q == S_IDLE && !wb_hold && tready_q) begin
        pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  assign step_done = (cnt_q == 2'(STB_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q     <= S_IDLE;
      ch_q     <= 3'h0;
      cnt_q    <= 2'h0;
      tready_q <= 1'b0;
    end else begin
      cnt_q <= 2'h0;
      case (st_q)
        S_IDLE: begin
          ch_q <= 3'h0;
          if (!wb_hold && ctrl_q[CTRL_SCAN] && !tready_q) begin
            st_q <= S_BOFS;
          end else if (!wb_hold && tready_q && pend_q && !(lost && mode == FS_HOLD)) begin
            st_q <= S_RZ;
          end
        end
        S_BOFS: st_q <= S_BGN;
        S_BGN:  st_q <= S_BWZ;
        S_BWZ:  st_q <= S_BWG;
        S_BWG: begin
          ch_q <= ch_q + 3'h1;
          if (ch_q == 3'(NCH - 1)) begin
            tready_q <= 1'b1;
            st_q     <= S_IDLE;
          end else begin
            st_q <= S_BOFS;
          end
        end
        S_RZ:   st_q <= S_RG;
        S_RG:   st_q <= S_CALC;
        S_CALC: st_q <= S_HI;
        S_HI:   st_q <= S_HSTB;
        S_HSTB: begin
          cnt_q <= cnt_q + 2'h1;
          if (step_done) begin
            cnt_q <= 2'h0;
            st_q  <= S_LO;
          end
        end
        S_LO:   st_q <= S_SEL;
        S_SEL: begin
          cnt_q <= cnt_q + 2'h1;
          if (step_done) begin
            cnt_q <= 2'h0;
            ch_q  <= ch_q + 3'h1;
            st_q  <= (ch_q == 3'(NCH - 1)) ? S_IDLE : S_RZ;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // table memory port, shared with software parameter access while idle

  always_comb begin
    fsm_addr = 5'h00;
    case (st_q)
      S_BOFS:      fsm_addr = M_OFS + {2'b00, ch_q};
      S_BGN:       fsm_addr = M_GAIN + {2'b00, ch_q};
      S_BWZ, S_RZ: fsm_addr = M_ZT + {2'b00, ch_q};
      S_BWG, S_RG: fsm_addr = M_GT + {2'b00, ch_q};
      default:     fsm_addr = 5'h00;
    endcase
  end

  assign mem_addr  = wb_mem ? {1'b0, wb_adr_i[5:2]} : fsm_addr;
  assign mem_we    = wb_mem ? (wb_req & ~wb_stage_q & is_par & wb_we_i & (&wb_sel_i[1:0]))
                            : (st_q == S_BWZ || st_q == S_BWG);
  assign mem_wdata = wb_mem ? wb_dat_i[15:0]
                            : (st_q == S_BWZ) ? 16'(STD_ZERO + a_q) : 16'(STD_GAIN + b_q);

  aoic_mem #(
    .W  (16),
    .D  (32),
    .AW (5)
  ) u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // calibration datapath

  assign z_s   = {a_q[15], a_q};
  assign span  = 18'(signed'({mem_rdata[15], mem_rdata})) - 18'(z_s);
  assign prod  = 31'(signed'({1'b0, img_q[ch_q]})) * 31'(span);
  assign raw_d = 20'(z_s) + 20'(prod >>> 12);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_q      <= 16'h0000;
      b_q      <= 16'h0000;
      raw_q    <= 20'sh00000;
      code_q   <= 12'h000;
      forced_q <= 1'b0;
    end else begin
      if (st_q == S_BGN || st_q == S_RG) begin
        a_q <= mem_rdata;
      end
      if (st_q == S_BWZ) begin
        b_q <= mem_rdata;
      end
      if (st_q == S_CALC) begin
        raw_q    <= raw_d;
        forced_q <= lost && mode != FS_HOLD;
        if (lost && mode == FS_HIGH) begin
          code_q <= CODE_MAX;
        end else if (lost && mode == FS_LOW) begin
          code_q <= CODE_MIN;
        end else begin
          code_q <= clamp12(raw_d);
        end
      end
    end
  end

  // justification is applied to the calibrated code, never the raw image
  assign word_q = justify(~sync2_q[JB_J], code_q);

  ////////////////////////////////////////////////////////////////////////////
  // converter bus

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dac_o <= DAC_RST;
    end else begin
      if (st_q == S_HI) begin
        dac_o.data <= word_q[15:8];
      end else if (st_q == S_LO) begin
        dac_o.data <= word_q[7:0];
      end
      dac_o.hstb_n <= (st_q != S_HSTB);
      dac_o.sel_n  <= (st_q == S_SEL) ? ~(8'h01 << ch_q) : 8'hff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_jmp_drive:   assert property (!jmp_o.oe_n |-> $past(!sync2_q[3] && !sync2_q[4]))
    else $error("jumper buffer driven outside a read");
  chk_jmp_bits:    assert property (!jmp_o.oe_n |-> jmp_o.data == {5'h00, $past(sync2_q[2:0])})
    else $error("jumper buffer bits wrong");
  chk_jmp_unused:  assert property (jmp_o.data[7:3] == 5'h00)
    else $error("unused jumper bits not zero");
  chk_fs_hold:     assert property (lost && mode == FS_HOLD && st_q == S_IDLE |=> st_q == S_IDLE)
    else $error("scan ran in hold failsafe");
  chk_scan_ready:  assert property (st_q == S_RZ |-> tready_q)
    else $error("scan before tables built");
  chk_zero_tab:    assert property (st_q == S_BWZ |-> mem_we && mem_wdata == 16'(STD_ZERO + $past(mem_rdata)))
    else $error("zero table entry wrong");
  chk_clamp_neg:   assert property (st_q == S_HI && !forced_q && raw_q < 0 |-> code_q == CODE_MIN)
    else $error("negative result not clamped");
  chk_clamp_hi:    assert property (st_q == S_HI && !forced_q && raw_q > 20'sh00fff |-> code_q == CODE_MAX)
    else $error("over range result not clamped");
  chk_hi_byte:     assert property (st_q == S_HSTB |-> dac_o.data == word_q[15:8])
    else $error("high byte not on bus at strobe");
  chk_one_sel:     assert property ($onehot0(~dac_o.sel_n) && !(!dac_o.hstb_n && dac_o.sel_n != 8'hff))
    else $error("converter selects overlap");
  chk_sel_width:   assert property ($fell(dac_o.sel_n[0]) |-> !dac_o.sel_n[0] [*2] ##1 dac_o.sel_n[0])
    else $error("select pulse width wrong");
  chk_wb_ack:      assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  cov_tables:  cover property ($rose(tready_q));
  cov_left:    cover property (st_q == S_HI && !sync2_q[JB_J]);
  cov_forced:  cover property (st_q == S_HI && forced_q);
  cov_jmp_rd:  cover property (!jmp_o.oe_n);

endmodule
`default_nettype wire

// ---- aoic_ctl_model.sv ----
// controller model: sends update messages of eight output images
`timescale 1ns/1ps
`default_nettype none
module aoic_ctl_model
  import aoic_pkg::*;
(
  // clock
  input  wire logic             clk_i,
  // update message
  output logic                  msg_valid_o,
  output logic      [MSG_W-1:0] msg_data_o
);
  initial begin
    msg_valid_o = 1'b0;
    msg_data_o = '0;
  end

  // one pulse; afterwards the bytes are inverted so stale data never looks valid
  task automatic send(input logic [11:0] img [8]);
    logic [MSG_W-1:0] m;
    for (int n = 0; n < NCH; n++) begin
      m[16*n +: 16] = {img[n][7:0], 4'h0, img[n][11:8]};
    end
    msg_valid_o <= 1'b1;
    msg_data_o <= m;
    @(posedge clk_i);
    msg_valid_o <= 1'b0;
    msg_data_o <= ~m;
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// self-checking testbench for the analog output image conditioner
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import aoic_pkg::*;
  logic             clk_i, rst_i, wb_cyc, wb_stb, wb_we, ack, mv, psel_n, rd_n, lvl, hold;
  logic [7:0]       wb_adr;
  logic [31:0]      wb_dat, rdat, q;
  logic [MSG_W-1:0] md;
  logic [2:0]       strap_n;
  aoic_jmp_t        jmp;
  aoic_dac_t        dac, dac_p;
  logic [18:0]      recs[$];
  logic [7:0]       hi;
  logic [11:0]      img [8];
  logic [15:0]      ew [8];
  int               fails, checks, ofs [8], gn [8];
  int               seed = 32'h522e;

  aoic_top aoic_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .msg_valid_i(mv), .msg_data_i(md), .strap_n_i(strap_n),
    .port_select_low_line_i(psel_n), .proc_rd_n_i(rd_n), .jmp_o(jmp), .dac_o(dac),
    .failsafe_level_ctl_o(lvl), .failsafe_hold_ctl_o(hold));
  aoic_ctl_model aoic_ctl_model_inst (.clk_i(clk_i), .msg_valid_o(mv), .msg_data_o(md));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 300);
    q = rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
    if (n >= 300) begin
      fails++;
      conclude();
    end
  endtask

  // converter bus monitor: high byte at strobe fall, low byte and channel at select fall
  always @(posedge clk_i) begin
    dac_p <= dac;
    if (!rst_i && dac_p.hstb_n && !dac.hstb_n) hi = dac.data;
    if (!rst_i && dac_p.sel_n == 8'hff && dac.sel_n != 8'hff) begin
      chk("one select", 32'd1, $countones(~dac.sel_n));
      for (int c = 0; c < NCH; c++) begin
        if (!dac.sel_n[c]) recs.push_back({c[2:0], hi, dac.data});
      end
    end
  end

  function automatic logic [15:0] word_of(input logic [11:0] i, input int o, input int g, input logic left);
    int z, gg, c;
    z = int'(STD_ZERO_DEF) + o;
    gg = int'(STD_GAIN_DEF) + g;
    c = z + ((int'(i) * (gg - z)) >>> 12);
    if (c < 0) c = 0;
    if (c > 4095) c = 4095;
    return left ? {c[11:0], 4'h0} : {4'h0, c[11:0]};
  endfunction

  function automatic logic [2:0] mode_of(input logic [1:0] ab_n);
    return ab_n == 2'b10 ? 3'b001 : (ab_n == 2'b01 ? 3'b010 : 3'b100);
  endfunction

  task automatic take_scan(input string nm);
    int n;
    n = 0;
    while (recs.size() < NCH && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    chk("scan length", 32'd8, recs.size());
    if (recs.size() < NCH) conclude();
    for (int c = 0; c < NCH; c++) begin
      chk("channel", c, recs[0][18:16]);
      chk(nm, ew[c], recs[0][15:0]);
      void'(recs.pop_front());
    end
    $display("test %s done", nm);
  endtask

  task automatic set_strap(input logic [2:0] s);
    strap_n <= s;
    repeat (4) @(posedge clk_i);
  endtask

  initial begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
    {psel_n, rd_n} = 2'b11;
    strap_n = 3'b111;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("dac reset", DAC_RST, dac);
    chk("jmp reset", JMP_RST, jmp);
    for (int k = 0; k < 4; k++) begin
      set_strap({1'b1, k[1:0]});
      wb(1'b0, A_STAT, 32'h0);
      chk("strap field", {1'b1, k[1:0]}, q[4:2]);
      chk("mode", mode_of(k[1:0]), q[7:5]);
      chk("level ctl", k == 2, lvl);
      psel_n <= 1'b0;
      rd_n <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("jumper read", {5'h00, 1'b1, k[1:0], 1'b0}, jmp);
      rd_n <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk("jumper released", JMP_RST, jmp);
      psel_n <= 1'b1;
    end
    $display("test straps done");
    wb(1'b1, 8'h20, 32'hffff_ffff);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    for (int c = 0; c < NCH; c++) begin
      ofs[c] = $random(seed) % 900;
      gn[c] = $random(seed) % 600;
      wb(1'b1, 8'h40 + 8'(4 * c), 32'(ofs[c]));
      wb(1'b1, 8'h60 + 8'(4 * c), 32'(gn[c]));
    end
    wb(1'b0, 8'h44, 32'h0);
    chk("param readback", {16'h0, 16'(ofs[1])}, q);
    wb(1'b1, A_CTRL, 32'h1);
    for (int n = 0; n < 300 && q[ST_READY] !== 1'b1; n++) wb(1'b0, A_STAT, 32'h0);
    chk("tables ready", 1'b1, q[ST_READY]);
    for (int j = 0; j < 4; j++) begin
      set_strap({j[0], 2'b11});
      for (int c = 0; c < NCH; c++) begin
        img[c] = j < 2 ? (c[0] ? 12'hfff : 12'h000) : 12'($random(seed));
        ew[c] = word_of(img[c], ofs[c], gn[c], !j[0]);
      end
      aoic_ctl_model_inst.send(img);
      take_scan("update");
    end
    for (int m = 0; m < 2; m++) begin
      set_strap(m[0] ? 3'b101 : 3'b110);
      wb(1'b1, A_CTRL, 32'h3);
      for (int c = 0; c < NCH; c++) ew[c] = {4'h0, m ? 12'h000 : 12'hfff};
      take_scan("failsafe");
      chk("level in lost", m == 0, lvl);
      wb(1'b1, A_CTRL, 32'h1);
    end
    set_strap(3'b111);
    wb(1'b1, A_CTRL, 32'h3);
    aoic_ctl_model_inst.send(img);
    repeat (200) @(posedge clk_i);
    chk("hold ctl", 1'b1, hold);
    chk("hold no scan", 32'd0, recs.size());
    $display("test hold done");
    conclude();
  end
endmodule
`default_nettype wire
